// *** core/ppcn_pkg.sv ***
// Purpose: Shared constants for the parallel port and change notice block.
// Assumes: 16-bit register bus with byte offsets as printed.
// Notes:   Implemented-bit masks double as the direction reset values.
package ppcn_pkg;

  localparam int          PPCN_DW            = 16;
  localparam int          PPCN_AW            = 16;
  localparam int          PPCN_CN_COUNT      = 10;

  localparam logic [15:0] PPCN_OFF_B_DIR     = 16'h02c6;
  localparam logic [15:0] PPCN_OFF_B_PIN     = 16'h02c8;
  localparam logic [15:0] PPCN_OFF_B_LAT     = 16'h02ca;
  localparam logic [15:0] PPCN_OFF_C_DIR     = 16'h02cc;
  localparam logic [15:0] PPCN_OFF_C_PIN     = 16'h02ce;
  localparam logic [15:0] PPCN_OFF_C_LAT     = 16'h02d0;
  localparam logic [15:0] PPCN_OFF_D_DIR     = 16'h02d2;
  localparam logic [15:0] PPCN_OFF_D_PIN     = 16'h02d4;
  localparam logic [15:0] PPCN_OFF_D_LAT     = 16'h02d6;
  localparam logic [15:0] PPCN_OFF_E_DIR     = 16'h02d8;
  localparam logic [15:0] PPCN_OFF_E_PIN     = 16'h02da;
  localparam logic [15:0] PPCN_OFF_E_LAT     = 16'h02dc;
  localparam logic [15:0] PPCN_OFF_F_DIR     = 16'h02de;
  localparam logic [15:0] PPCN_OFF_F_PIN     = 16'h02e0;
  localparam logic [15:0] PPCN_OFF_F_LAT     = 16'h02e2;

  localparam logic [15:0] PPCN_OFF_CN_ENABLE = 16'h0300;
  localparam logic [15:0] PPCN_OFF_CN_STATUS = 16'h0302;
  localparam logic [15:0] PPCN_OFF_CN_MASK   = 16'h0304;

  localparam logic [15:0] PPCN_RST_B_DIR     = 16'h01ff;
  localparam logic [15:0] PPCN_RST_C_DIR     = 16'he000;
  localparam logic [15:0] PPCN_RST_D_DIR     = 16'h000f;
  localparam logic [15:0] PPCN_RST_E_DIR     = 16'h013f;
  localparam logic [15:0] PPCN_RST_F_DIR     = 16'h007f;
  localparam logic [15:0] PPCN_RST_LAT       = 16'h0000;
  localparam logic [15:0] PPCN_RST_PIN       = 16'h0000;

  localparam logic [15:0] PPCN_IMPL_B        = 16'h01ff;
  localparam logic [15:0] PPCN_IMPL_C        = 16'he000;
  localparam logic [15:0] PPCN_IMPL_D        = 16'h000f;
  localparam logic [15:0] PPCN_IMPL_E        = 16'h013f;
  localparam logic [15:0] PPCN_IMPL_F        = 16'h007f;

  localparam logic [9:0]  PPCN_RST_CN        = 10'h000;

endpackage : ppcn_pkg

// *** core/ppcn_port.sv ***
// Purpose: One parallel port: direction bits, output latch, pin sampling.
// Assumes: Pin inputs are synchronous to clk.
// Notes:   Unimplemented bits are held at zero in every flop.
`timescale 1ns/100ps
`default_nettype none
module ppcn_port
  import ppcn_pkg::*;
#(
  parameter int          W        = 16,
  parameter logic [15:0] IMPL     = 16'hffff,
  parameter logic [15:0] DIR_RST  = 16'hffff
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         dir_we,
  input  wire logic         lat_we,
  input  wire logic [W-1:0] wdata,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] dir_q,
  output logic      [W-1:0] lat_q,
  output logic      [W-1:0] pin_q,
  output logic      [W-1:0] pin_out,
  output logic      [W-1:0] pin_oe
);

  logic [W-1:0] dir_reg;
  logic [W-1:0] dir_next;
  logic [W-1:0] lat_reg;
  logic [W-1:0] oe_reg;
  logic [W-1:0] pin_reg;

  if (W != 16) begin : g_chk
    $error("ppcn_port supports only 16-bit ports.");
  end

  always_comb begin
    dir_next = dir_we ? (wdata & IMPL) : dir_reg;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dir_reg <= DIR_RST & IMPL;
      oe_reg  <= ~DIR_RST & IMPL;
    end else begin
      dir_reg <= dir_next;
      oe_reg  <= ~dir_next & IMPL;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lat_reg <= PPCN_RST_LAT;
    end else if (lat_we) begin
      lat_reg <= wdata & IMPL;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_reg <= PPCN_RST_PIN;
    end else begin
      pin_reg <= pin_in & IMPL;
    end
  end

  assign dir_q   = dir_reg;
  assign lat_q   = lat_reg;
  assign pin_q   = pin_reg;
  assign pin_out = lat_reg;
  assign pin_oe  = oe_reg;

endmodule : ppcn_port
`default_nettype wire

// *** core/ppcn_top.sv ***
// Purpose: Parallel ports B to F with input change notification.
// Assumes: Register bus strobes are one cycle long; pins synchronous to clk.
// Notes:   Read data appear in the cycle after the read strobe.
//
// The plain strobed port was decided locally.
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Bits a port does not implement read as zero and ignore writes.
// - A change on a watched input raises the interrupt request.
// - The change comparison is pure logic and holds its result while the clock is stopped.
// - Ten change notice inputs exist, numbered 0 to 7, 17 and 18.
// - Each change notice input has its own enable, and only enabled inputs flag changes.
// - A direction bit of one makes the pin an input, zero makes it drive the latch.
// - Pin state reads return sampled pins, its writes and latch accesses reach the latch.
// - After reset every implemented pin is an input.
module ppcn_top
  import ppcn_pkg::*;
#(
  parameter int CN_COUNT = PPCN_CN_COUNT
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic [PPCN_AW-1:0]  bus_addr,
  input  wire logic [PPCN_DW-1:0]  bus_wdata,
  input  wire logic                bus_wr,
  input  wire logic                bus_rd,
  output logic      [PPCN_DW-1:0]  bus_rdata,
  input  wire logic [15:0]         pin_in_b,
  output logic      [15:0]         pin_out_b,
  output logic      [15:0]         pin_oe_b,
  input  wire logic [15:0]         pin_in_c,
  output logic      [15:0]         pin_out_c,
  output logic      [15:0]         pin_oe_c,
  input  wire logic [15:0]         pin_in_d,
  output logic      [15:0]         pin_out_d,
  output logic      [15:0]         pin_oe_d,
  input  wire logic [15:0]         pin_in_e,
  output logic      [15:0]         pin_out_e,
  output logic      [15:0]         pin_oe_e,
  input  wire logic [15:0]         pin_in_f,
  output logic      [15:0]         pin_out_f,
  output logic      [15:0]         pin_oe_f,
  input  wire logic [CN_COUNT-1:0] change_notice_input,
  output logic                     irq
);

  if (CN_COUNT != PPCN_CN_COUNT) begin : g_chk
    $error("ppcn_top needs exactly ten change notice inputs.");
  end

  logic [15:0]         dir_b;
  logic [15:0]         lat_b;
  logic [15:0]         pin_b;
  logic [15:0]         dir_c;
  logic [15:0]         lat_c;
  logic [15:0]         pin_c;
  logic [15:0]         dir_d;
  logic [15:0]         lat_d;
  logic [15:0]         pin_d;
  logic [15:0]         dir_e;
  logic [15:0]         lat_e;
  logic [15:0]         pin_e;
  logic [15:0]         dir_f;
  logic [15:0]         lat_f;
  logic [15:0]         pin_f;

  logic                we_dir_b;
  logic                we_lat_b;
  logic                we_dir_c;
  logic                we_lat_c;
  logic                we_dir_d;
  logic                we_lat_d;
  logic                we_dir_e;
  logic                we_lat_e;
  logic                we_dir_f;
  logic                we_lat_f;

  logic [CN_COUNT-1:0] cn_enable_reg;
  logic [CN_COUNT-1:0] cn_mask_reg;
  logic [CN_COUNT-1:0] cn_mask_next;
  logic [CN_COUNT-1:0] cn_status_reg;
  logic [CN_COUNT-1:0] cn_status_next;
  logic [CN_COUNT-1:0] cn_prev_reg;
  logic [CN_COUNT-1:0] change_of_state;
  logic [CN_COUNT-1:0] cn_clear;
  logic                irq_reg;
  logic [PPCN_DW-1:0]  rdata_reg;

  // Write decode; a pin state write lands in the latch.
  assign we_dir_b = bus_wr && (bus_addr == PPCN_OFF_B_DIR);
  assign we_lat_b = bus_wr && ((bus_addr == PPCN_OFF_B_LAT) ||
                               (bus_addr == PPCN_OFF_B_PIN));
  assign we_dir_c = bus_wr && (bus_addr == PPCN_OFF_C_DIR);
  assign we_lat_c = bus_wr && ((bus_addr == PPCN_OFF_C_LAT) ||
                               (bus_addr == PPCN_OFF_C_PIN));
  assign we_dir_d = bus_wr && (bus_addr == PPCN_OFF_D_DIR);
  assign we_lat_d = bus_wr && ((bus_addr == PPCN_OFF_D_LAT) ||
                               (bus_addr == PPCN_OFF_D_PIN));
  assign we_dir_e = bus_wr && (bus_addr == PPCN_OFF_E_DIR);
  assign we_lat_e = bus_wr && ((bus_addr == PPCN_OFF_E_LAT) ||
                               (bus_addr == PPCN_OFF_E_PIN));
  assign we_dir_f = bus_wr && (bus_addr == PPCN_OFF_F_DIR);
  assign we_lat_f = bus_wr && ((bus_addr == PPCN_OFF_F_LAT) ||
                               (bus_addr == PPCN_OFF_F_PIN));

  ppcn_port #(
    .W       (16),
    .IMPL    (PPCN_IMPL_B),
    .DIR_RST (PPCN_RST_B_DIR)
  ) u_port_b (
    .clk     (clk),
    .rst_n   (rst_n),
    .dir_we  (we_dir_b),
    .lat_we  (we_lat_b),
    .wdata   (bus_wdata),
    .pin_in  (pin_in_b),
    .dir_q   (dir_b),
    .lat_q   (lat_b),
    .pin_q   (pin_b),
    .pin_out (pin_out_b),
    .pin_oe  (pin_oe_b)
  );

  ppcn_port #(
    .W       (16),
    .IMPL    (PPCN_IMPL_C),
    .DIR_RST (PPCN_RST_C_DIR)
  ) u_port_c (
    .clk     (clk),
    .rst_n   (rst_n),
    .dir_we  (we_dir_c),
    .lat_we  (we_lat_c),
    .wdata   (bus_wdata),
    .pin_in  (pin_in_c),
    .dir_q   (dir_c),
    .lat_q   (lat_c),
    .pin_q   (pin_c),
    .pin_out (pin_out_c),
    .pin_oe  (pin_oe_c)
  );

  ppcn_port #(
    .W       (16),
    .IMPL    (PPCN_IMPL_D),
    .DIR_RST (PPCN_RST_D_DIR)
  ) u_port_d (
    .clk     (clk),
    .rst_n   (rst_n),
    .dir_we  (we_dir_d),
    .lat_we  (we_lat_d),
    .wdata   (bus_wdata),
    .pin_in  (pin_in_d),
    .dir_q   (dir_d),
    .lat_q   (lat_d),
    .pin_q   (pin_d),
    .pin_out (pin_out_d),
    .pin_oe  (pin_oe_d)
  );

  ppcn_port #(
    .W       (16),
    .IMPL    (PPCN_IMPL_E),
    .DIR_RST (PPCN_RST_E_DIR)
  ) u_port_e (
    .clk     (clk),
    .rst_n   (rst_n),
    .dir_we  (we_dir_e),
    .lat_we  (we_lat_e),
    .wdata   (bus_wdata),
    .pin_in  (pin_in_e),
    .dir_q   (dir_e),
    .lat_q   (lat_e),
    .pin_q   (pin_e),
    .pin_out (pin_out_e),
    .pin_oe  (pin_oe_e)
  );

  ppcn_port #(
    .W       (16),
    .IMPL    (PPCN_IMPL_F),
    .DIR_RST (PPCN_RST_F_DIR)
  ) u_port_f (
    .clk     (clk),
    .rst_n   (rst_n),
    .dir_we  (we_dir_f),
    .lat_we  (we_lat_f),
    .wdata   (bus_wdata),
    .pin_in  (pin_in_f),
    .dir_q   (dir_f),
    .lat_q   (lat_f),
    .pin_q   (pin_f),
    .pin_out (pin_out_f),
    .pin_oe  (pin_oe_f)
  );

  // The mismatch is held by the captured level, so no edge is needed to keep it.
  assign change_of_state = (change_notice_input ^ cn_prev_reg) & cn_enable_reg;

  assign cn_clear = (bus_wr && (bus_addr == PPCN_OFF_CN_STATUS)) ?
                    bus_wdata[CN_COUNT-1:0] : {CN_COUNT{1'b0}};

  // A change in the cycle of its clear still sets the flag.
  always_comb begin
    cn_status_next = (cn_status_reg & ~cn_clear) | change_of_state;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cn_prev_reg <= PPCN_RST_CN;
    end else begin
      cn_prev_reg <= change_notice_input;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cn_status_reg <= PPCN_RST_CN;
    end else begin
      cn_status_reg <= cn_status_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cn_enable_reg <= PPCN_RST_CN;
    end else if (bus_wr && (bus_addr == PPCN_OFF_CN_ENABLE)) begin
      cn_enable_reg <= bus_wdata[CN_COUNT-1:0];
    end
  end

  // The interrupt follows a mask write in the same cycle as the mask register does.
  always_comb begin
    cn_mask_next = (bus_wr && (bus_addr == PPCN_OFF_CN_MASK)) ?
                   bus_wdata[CN_COUNT-1:0] : cn_mask_reg;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cn_mask_reg <= PPCN_RST_CN;
    end else begin
      cn_mask_reg <= cn_mask_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(cn_status_next & cn_mask_next);
    end
  end

  // Read port; unmapped offsets and idle cycles return zero.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_reg <= 16'h0000;
    end else if (bus_rd) begin
      case (bus_addr)
        PPCN_OFF_B_DIR:     rdata_reg <= dir_b;
        PPCN_OFF_B_PIN:     rdata_reg <= pin_b;
        PPCN_OFF_B_LAT:     rdata_reg <= lat_b;
        PPCN_OFF_C_DIR:     rdata_reg <= dir_c;
        PPCN_OFF_C_PIN:     rdata_reg <= pin_c;
        PPCN_OFF_C_LAT:     rdata_reg <= lat_c;
        PPCN_OFF_D_DIR:     rdata_reg <= dir_d;
        PPCN_OFF_D_PIN:     rdata_reg <= pin_d;
        PPCN_OFF_D_LAT:     rdata_reg <= lat_d;
        PPCN_OFF_E_DIR:     rdata_reg <= dir_e;
        PPCN_OFF_E_PIN:     rdata_reg <= pin_e;
        PPCN_OFF_E_LAT:     rdata_reg <= lat_e;
        PPCN_OFF_F_DIR:     rdata_reg <= dir_f;
        PPCN_OFF_F_PIN:     rdata_reg <= pin_f;
        PPCN_OFF_F_LAT:     rdata_reg <= lat_f;
        PPCN_OFF_CN_ENABLE: rdata_reg <= {6'h00, cn_enable_reg};
        PPCN_OFF_CN_STATUS: rdata_reg <= {6'h00, cn_status_reg};
        PPCN_OFF_CN_MASK:   rdata_reg <= {6'h00, cn_mask_reg};
        default:            rdata_reg <= 16'h0000;
      endcase
    end else begin
      rdata_reg <= 16'h0000;
    end
  end

  assign bus_rdata = rdata_reg;
  assign irq       = irq_reg;

endmodule : ppcn_top
`default_nettype wire

// *** testbench/ppcn_properties.sv ***
// Purpose: Concurrent checks on the port and change notice block.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Bound to the top module below.
`timescale 1ns/100ps
`default_nettype none
module ppcn_properties
  import ppcn_pkg::*;
#(
  parameter int CN_COUNT = PPCN_CN_COUNT
) (
  input wire logic                clk,
  input wire logic                rst_n,
  input wire logic [PPCN_AW-1:0]  bus_addr,
  input wire logic [PPCN_DW-1:0]  bus_wdata,
  input wire logic                bus_wr,
  input wire logic                bus_rd,
  input wire logic [PPCN_DW-1:0]  bus_rdata,
  input wire logic [15:0]         pin_in_b,
  input wire logic [15:0]         pin_out_b,
  input wire logic [15:0]         pin_oe_b,
  input wire logic [15:0]         pin_oe_c,
  input wire logic [CN_COUNT-1:0] change_notice_input,
  input wire logic                irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [CN_COUNT-1:0] en_reg;
  logic [CN_COUNT-1:0] mask_reg;
  // Shadows of the enable and mask registers, kept from bus writes.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      en_reg   <= '0;
      mask_reg <= '0;
    end else if (bus_wr && bus_addr == PPCN_OFF_CN_ENABLE) begin
      en_reg <= bus_wdata[CN_COUNT-1:0];
    end else if (bus_wr && bus_addr == PPCN_OFF_CN_MASK) begin
      mask_reg <= bus_wdata[CN_COUNT-1:0];
    end
  end
  chk_unimpl_zero: assert property (
    ((pin_oe_b | pin_out_b) & ~PPCN_IMPL_B) == 0 && (pin_oe_c & ~PPCN_IMPL_C) == 0)
    else $error("unimplemented pin bit active");
  chk_reset_input: assert property (
    !$past(rst_n) |-> pin_oe_b == 0 && pin_oe_c == 0)
    else $error("pin driven after reset");
  chk_dir_drives: assert property (
    bus_wr && bus_addr == PPCN_OFF_B_DIR |=> pin_oe_b == (~$past(bus_wdata) & PPCN_IMPL_B))
    else $error("enable does not follow direction");
  chk_latch_write: assert property (
    bus_wr && (bus_addr == PPCN_OFF_B_LAT || bus_addr == PPCN_OFF_B_PIN)
    |=> pin_out_b == ($past(bus_wdata) & PPCN_IMPL_B))
    else $error("latch write lost");
  chk_pin_read: assert property (
    bus_rd && bus_addr == PPCN_OFF_B_PIN && $past(rst_n)
    |=> bus_rdata == ($past(pin_in_b, 2) & PPCN_IMPL_B))
    else $error("pin read mismatch");
  chk_unmapped_zero: assert property (
    bus_rd && bus_addr == 16'h02e4 |=> bus_rdata == 0)
    else $error("unmapped read not zero");
  chk_irq_raise: assert property (
    $past(rst_n, 2) && $past(rst_n) && !$past(bus_wr) && |(($past(change_notice_input)
    ^ $past(change_notice_input, 2)) & $past(en_reg & mask_reg)) |-> irq)
    else $error("change did not raise irq");
  chk_irq_quiet: assert property (
    $past(change_notice_input) == $past(change_notice_input, 2) && !$past(bus_wr)
    |-> $stable(irq))
    else $error("irq moved without cause");
  cover property (bus_rd && bus_addr == PPCN_OFF_B_PIN);
  cover property ($rose(irq));
  cover property ($fell(irq));
endmodule : ppcn_properties
bind ppcn_top ppcn_properties #(.CN_COUNT(CN_COUNT)) u_chk (.*);
`default_nettype wire

// *** testbench/ppcn_pins_model.sv ***
// Purpose: Board model resolving each port pin from driver and board level.
// Assumes: Board levels change just after a clock edge.
// Notes:   An undriven pin shows the board level, not the stale latch.
`timescale 1ns/100ps
`default_nettype none
module ppcn_pins_model (
  input  wire logic [79:0] pin_out,
  input  wire logic [79:0] pin_oe,
  input  wire logic [79:0] board,
  output logic      [79:0] pin_in
);
  always_comb pin_in = (pin_out & pin_oe) | (board & ~pin_oe);
endmodule : ppcn_pins_model
`default_nettype wire

// *** testbench/ppcn_tb_top.sv ***
// Purpose: Self-checking bench for the port and change notice block.
// Assumes: Direction reset values equal the implemented masks.
// Notes:   Ports B to F sit in 16-bit slices of the pin vectors.
`timescale 1ns/100ps
`default_nettype none
module parallel_port_with_change_notify_tb_top
  import ppcn_pkg::*;
;
  logic        clk = 1'b0;
  logic        clk_on = 1'b1;
  logic        rst_n = 1'b0;
  logic [15:0] bus_addr = '0;
  logic [15:0] bus_wdata = '0;
  logic        bus_wr = 1'b0;
  logic        bus_rd = 1'b0;
  logic [15:0] bus_rdata;
  logic [79:0] pin_in;
  logic [79:0] pin_out;
  logic [79:0] pin_oe;
  logic [79:0] board = '0;
  logic [9:0]  cn = '0;
  logic        irq;
  int          errors = 0;
  int          checks_done = 0;
  logic [15:0] impl [5] = '{PPCN_IMPL_B, PPCN_IMPL_C, PPCN_IMPL_D, PPCN_IMPL_E, PPCN_IMPL_F};
  always #5 clk = ~clk & clk_on;
  ppcn_top uut (
    .clk(clk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .pin_in_b(pin_in[15:0]), .pin_out_b(pin_out[15:0]), .pin_oe_b(pin_oe[15:0]),
    .pin_in_c(pin_in[31:16]), .pin_out_c(pin_out[31:16]), .pin_oe_c(pin_oe[31:16]),
    .pin_in_d(pin_in[47:32]), .pin_out_d(pin_out[47:32]), .pin_oe_d(pin_oe[47:32]),
    .pin_in_e(pin_in[63:48]), .pin_out_e(pin_out[63:48]), .pin_oe_e(pin_oe[63:48]),
    .pin_in_f(pin_in[79:64]), .pin_out_f(pin_out[79:64]), .pin_oe_f(pin_oe[79:64]),
    .change_notice_input(cn), .irq(irq)
  );
  ppcn_pins_model u_pins (.pin_out(pin_out), .pin_oe(pin_oe), .board(board), .pin_in(pin_in));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clk);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1 check(bus_rdata, exp);
  endtask : rd
  task automatic report_and_stop;
    $display("checks %0d, errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  initial begin
    #100000;
    errors++;
    report_and_stop();
  end
  initial begin
    logic [15:0] a;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    #1 check(16'(|pin_oe), 16'h0000);
    for (int i = 0; i < 5; i++) begin
      a = PPCN_OFF_B_DIR + 16'(6 * i);
      rd(a, impl[i]);
      rd(a + 16'h4, 16'h0000);
      wr(a + 16'h4, 16'hffff);
      rd(a + 16'h4, impl[i]);
      wr(a + 16'h2, 16'h5555);
      rd(a + 16'h4, 16'h5555 & impl[i]);
      wr(a, 16'h0000);
      check(pin_oe[16*i +: 16], impl[i]);
      check(pin_out[16*i +: 16], 16'h5555 & impl[i]);
      rd(a + 16'h2, 16'h5555 & impl[i]);
      wr(a, 16'hffff);
      check(pin_oe[16*i +: 16], 16'h0000);
      rd(a, impl[i]);
      @(posedge clk) board[16*i +: 16] <= 16'hc3a5;
      rd(a + 16'h2, 16'hc3a5 & impl[i]);
    end
    rd(16'h02e4, 16'h0000);
    wr(PPCN_OFF_CN_ENABLE, 16'h0001);
    wr(PPCN_OFF_CN_MASK, 16'h03ff);
    @(posedge clk) cn <= 10'h002;
    rd(PPCN_OFF_CN_STATUS, 16'h0000);
    check({15'h0, irq}, 16'h0000);
    @(posedge clk) cn <= 10'h003;
    rd(PPCN_OFF_CN_STATUS, 16'h0001);
    check({15'h0, irq}, 16'h0001);
    wr(PPCN_OFF_CN_STATUS, 16'h0001);
    check({15'h0, irq}, 16'h0000);
    wr(PPCN_OFF_CN_ENABLE, 16'h03ff);
    for (int i = 0; i < 10; i++) begin
      @(posedge clk) cn <= cn ^ 10'(1 << i);
      rd(PPCN_OFF_CN_STATUS, 16'(1 << i));
      wr(PPCN_OFF_CN_STATUS, 16'(1 << i));
    end
    wr(PPCN_OFF_CN_MASK, 16'h0000);
    @(posedge clk) cn <= cn ^ 10'h200;
    rd(PPCN_OFF_CN_STATUS, 16'h0200);
    check({15'h0, irq}, 16'h0000);
    wr(PPCN_OFF_CN_MASK, 16'h03ff);
    check({15'h0, irq}, 16'h0001);
    wr(PPCN_OFF_CN_STATUS, 16'h0200);
    @(negedge clk) clk_on = 1'b0;
    #53 cn <= cn ^ 10'h001;
    #51 clk_on = 1'b1;
    rd(PPCN_OFF_CN_STATUS, 16'h0001);
    check({15'h0, irq}, 16'h0001);
    report_and_stop();
  end
endmodule : parallel_port_with_change_notify_tb_top
`default_nettype wire
